// [bench/page_source.sv]
// Behavioural page source: streams stored bytes with valid/ready and random stalls.
// Assumes the bench loads mem and len, then pulses go with the checker's start.
`timescale 1ns/1ns
module page_source (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic go,
  // Byte stream
  input  wire logic byteReady,
  output logic      byteValid,
  output logic [7:0] byteData
);
  logic [7:0] mem [0:4095];
  int         len = 0;
  int         idx = 0;
  logic       active = 1'b0;
  integer     seed = 94825;

  // Idle line at time zero
  initial begin
    byteValid = 1'b0;
    byteData = 8'h00;
  end

  // Offer bytes in order, hold each until taken, scramble the line when idle
  always @(posedge mclk) begin
    if (srst || go) begin
      idx = 0;
      active = go;
      byteValid <= 1'b0;
    end else if (byteValid && !byteReady) begin
      byteValid <= 1'b1;
    end else begin
      if (byteValid) idx = idx + 1;
      if (active && idx < len && ({$random(seed)} % 4) != 0) begin
        byteValid <= 1'b1;
        byteData <= mem[idx];
      end else begin
        byteValid <= 1'b0;
        byteData <= ~byteData;
      end
    end
  end
endmodule

// [bench/param_page_crc_checker_tb.sv]
// Self-checking bench for the page CRC checker with a streaming page source.
// Assumes page_source and the bound checker are compiled alongside.
`timescale 1ns/1ns
module param_page_crc_checker_tb;
  import ppcrc_pkg::*;
  localparam logic [31:0] SIG = 32'hC35A96E1; // Arbitrary signature value
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       start = 1'b0;
  logic       go = 1'b0;
  logic       byteValid, byteReady, resultStrobe, busy, done;
  logic [7:0] byteData;
  result_t    result, e;
  result_t    expQ[$];
  integer     seed = 94825;
  int         err_count = 0;
  int         num_checks = 0;

  always #25 mclk = ~mclk;

  param_page_crc_checker u_dut (.mclk, .srst, .start, .sigWord(SIG), .byteValid, .byteData, .byteReady,
    .result, .resultStrobe, .busy, .done);
  page_source u_src (.mclk, .srst, .go, .byteReady, .byteValid, .byteData);

  // ------
  // Helpers
  // ------
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] crcOf(input int base);
    logic [15:0] c;
    c = CRC_SEED;
    for (int i = 0; i < 510; i++)
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ u_src.mem[base+i][b]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction

  // Kind 0 good, 1 corrupted, 2 absent
  task automatic makeCopy(input int c, input int kind);
    int base;
    base = 512 * c;
    for (int i = 0; i < 510; i++) u_src.mem[base+i] = 8'($random(seed));
    for (int i = 0; i < 4; i++) u_src.mem[base+i] = SIG[8*i +: 8] ^ (((c >= 3 && i >= 2) || (kind == 2 && i >= 1)) ? 8'hFF : 8'h00);
    {u_src.mem[base+511], u_src.mem[base+510]} = crcOf(base);
    if (kind == 1) u_src.mem[base + ((c == 1) ? 511 : 37 * c + 5)] ^= 8'h10;
    e = '0;
    e.copy = 8'(c);
    e.crc = crcOf(base);
    e.pass = (kind == 0);
    e.fail = (kind == 1);
    e.absent = (kind == 2);
    expQ.push_back(e);
  endtask

  task automatic runPage(input int nBad, input int last);
    for (int c = 0; c < nBad; c++) makeCopy(c, 1);
    makeCopy(nBad, last);
    u_src.len = 512 * (nBad + 1);
    @(posedge mclk);
    start <= 1'b1;
    go <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    go <= 1'b0;
    @(negedge mclk);
    check("busy", busy, 1'b1);
    for (int t = 0; t < 8000 && done !== 1'b1; t++) @(negedge mclk);
    repeat (2) @(negedge mclk);
    check("done", {done, busy, 8'(expQ.size())}, 10'h200);
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compare each verdict with the oldest expectation
  always @(negedge mclk) begin
    if (resultStrobe === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 'x;
      check("verdict", {result.pass, result.fail, result.absent, result.copy}, {e.pass, e.fail, e.absent, e.copy});
      if (e.absent !== 1'b1) check("crc", result.crc, e.crc);
    end
  end

  // Main sequence; the idle fill proves start flushes stale bytes
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    runPage(0, 0);
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (60) @(negedge mclk);
    check("full", byteReady, 1'b0);
    runPage(1, 0);
    runPage(2, 0);
    runPage(3, 0);
    runPage(4, 2);
    summarize();
  end

  // Watchdog
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
endmodule

// [bench/ppcrc_checker.sv]
// Assertions on the page CRC checker's stream and verdict ports.
// Assumes binding to param_page_crc_checker with its single clock mclk.
`timescale 1ns/1ns
module ppcrc_checker
  import ppcrc_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              srst,
  // Control and stream
  input wire logic              start,
  input wire logic [31:0]       sigWord,
  input wire logic              byteValid,
  input wire logic [BYTE_W-1:0] byteData,
  input wire logic              byteReady,
  // Verdict
  input wire result_t           result,
  input wire logic              resultStrobe,
  input wire logic              busy,
  input wire logic              done
);
  logic       prevFail_q;
  logic [7:0] prevCopy_q;

  // Last verdict of the current read; start clears the fail flag, not the copy index
  always_ff @(posedge mclk) begin
    if (srst || start) begin
      prevFail_q <= 1'b0;
    end else if (resultStrobe) begin
      prevFail_q <= result.fail;
      prevCopy_q <= result.copy;
    end
  end

  // ------
  // Properties
  // ------
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence sQuiet;
    !resultStrobe [*3];
  endsequence

  AST_STROBE_PULSE: assert property (resultStrobe |=> !resultStrobe)
    else $error("verdict strobe too long");
  AST_START_CLEARS: assert property (start |=> busy && !done && result == '0)
    else $error("start did not clear state");
  AST_ONE_VERDICT: assert property (resultStrobe |-> $onehot({result.pass, result.fail, result.absent}))
    else $error("verdict flags not one-hot");
  AST_FINAL_DONE: assert property (resultStrobe && !result.fail |-> ##[0:1] (done && !busy))
    else $error("final verdict without done");
  AST_FAIL_GOES_ON: assert property (resultStrobe && result.fail |-> busy && !done)
    else $error("fail verdict stopped the read");
  AST_FAIL_QUIET: assert property (resultStrobe && result.fail |=> sQuiet)
    else $error("verdict too soon after fail");
  AST_FIRST_COPY: assert property (resultStrobe && !prevFail_q |-> result.copy == 8'h00)
    else $error("first verdict not on primary");
  AST_COPY_STEP: assert property (resultStrobe && prevFail_q |-> result.copy == prevCopy_q + 8'h01)
    else $error("copy index did not advance");
  AST_ABSENT_LATE: assert property (resultStrobe && result.absent |-> result.copy >= COPY_FIXED)
    else $error("absent on a mandatory copy");
  AST_RESET_STATE: assert property (disable iff (1'b0) srst |=> byteReady && !busy && !done && !resultStrobe)
    else $error("reset state wrong");
endmodule

bind param_page_crc_checker ppcrc_checker u_chk (.mclk, .srst, .start, .sigWord, .byteValid, .byteData,
  .byteReady, .result, .resultStrobe, .busy, .done);

// [verilog/byte_fifo.sv]
// The byte FIFO module lives in param_page_crc_checker.sv, next to its only user.
// This file holds no logic.

// [verilog/param_page_crc_checker.sv]
// Parameter page integrity checker (CRC per copy, pass or advance) and its input byte FIFO.
// Assumes the byte stream comes from logic on mclk; start begins a read.
`timescale 1ns/1ns
module param_page_crc_checker
  import ppcrc_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // Control
  input  wire logic              start,
  input  wire logic [31:0]       sigWord,
  // Page byte stream
  input  wire logic              byteValid,
  input  wire logic [BYTE_W-1:0] byteData,
  output logic                   byteReady,
  // Verdict
  output result_t                result,
  output logic                   resultStrobe,
  output logic                   busy,
  output logic                   done
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  state_t            stateQ;
  logic [POS_W-1:0]  posQ;
  logic [CRC_W-1:0]  crcQ;
  logic [CRC_W-1:0]  storedQ;
  logic [2:0]        matchQ;
  logic [COPY_W-1:0] copyQ;
  logic              fifoValid;
  logic [BYTE_W-1:0] fifoData;
  logic              fifoInReady;
  logic              take;
  logic              probing;
  logic              sigHit;
  logic [2:0]        matchNext;
  logic              absentNow;
  logic [CRC_W-1:0]  crcNext;
  logic [BYTE_W-1:0] sigByte;
  logic              crcGood;

  // ---------------------------------------------------------------
  // CRC of one byte, bit 7 first, no reflection
  // ---------------------------------------------------------------
  function automatic logic [CRC_W-1:0] crcByte(input logic [CRC_W-1:0] c,
                                               input logic [BYTE_W-1:0] d);
    logic [CRC_W-1:0] r;
    logic             fb;
    r = c;
    for (int i = BYTE_W - 1; i >= 0; i--) begin
      fb = r[CRC_W-1] ^ d[i];
      r  = {r[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Input buffer
  // ---------------------------------------------------------------
  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .srst     (srst),
    .flush    (start),
    .inValid  (byteValid),
    .inData   (byteData),
    .inReady  (fifoInReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (take)
  );

  // Ready to the source comes from the FIFO's registered flag
  assign byteReady = fifoInReady;

  // ---------------------------------------------------------------
  // Per-byte decode
  // ---------------------------------------------------------------
  // Bytes are drained only while a copy is being consumed
  assign take = fifoValid && ((stateQ == ST_BODY) || (stateQ == ST_STORED));

  // Signature byte for the current position, byte 0 in the low lane
  always_comb begin
    case (posQ[1:0])
      2'b00:   sigByte = sigWord[7:0];
      2'b01:   sigByte = sigWord[15:8];
      2'b10:   sigByte = sigWord[23:16];
      default: sigByte = sigWord[31:24];
    endcase
  end

  // Presence probe on the first word of every copy past the mandatory ones
  assign probing   = (copyQ >= COPY_FIXED) && (posQ <= PROBE_LAST);
  assign sigHit    = probing && (fifoData == sigByte);
  assign matchNext = matchQ + 3'(sigHit);
  assign absentNow = take && (stateQ == ST_BODY) && probing
                     && (posQ == PROBE_LAST) && (matchNext < SIG_MIN);

  assign crcNext = crcByte(crcQ, fifoData);
  assign crcGood = (crcQ == storedQ);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      stateQ <= ST_IDLE;
    end else if (start) begin
      stateQ <= ST_BODY;
    end else begin
      case (stateQ)
        ST_IDLE: begin
          stateQ <= ST_IDLE;
        end
        ST_BODY: begin
          if (absentNow) begin
            stateQ <= ST_DONE;
          end else if (take && posQ == COVER_LAST) begin
            stateQ <= ST_STORED;
          end
        end
        ST_STORED: begin
          if (take && posQ == STORED_HI) begin
            stateQ <= ST_JUDGE;
          end
        end
        ST_JUDGE: begin
          // Pass stops; a failure moves on to the next copy
          stateQ <= crcGood ? ST_DONE : ST_BODY;
        end
        ST_DONE: begin
          stateQ <= ST_DONE;
        end
        default: begin
          stateQ <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Byte position within the current copy
  // ---------------------------------------------------------------
  // Wraps from 511 to 0, so copy n starts at stream byte 512*n
  always_ff @(posedge mclk) begin
    if (srst || start) begin
      posQ <= '0;
    end else if (take) begin
      posQ <= posQ + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // CRC register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || start) begin
      crcQ <= CRC_SEED;
    end else if (stateQ == ST_JUDGE) begin
      crcQ <= CRC_SEED;
    end else if (take && stateQ == ST_BODY) begin
      crcQ <= crcNext;
    end
  end

  // ---------------------------------------------------------------
  // Stored check word, low byte at 510, high byte at 511
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || start) begin
      storedQ <= '0;
    end else if (take && stateQ == ST_STORED) begin
      if (posQ == STORED_LO) begin
        storedQ[BYTE_W-1:0] <= fifoData;
      end else begin
        storedQ[CRC_W-1:BYTE_W] <= fifoData;
      end
    end
  end

  // ---------------------------------------------------------------
  // Signature match count for the presence probe
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || start || stateQ == ST_JUDGE) begin
      matchQ <= '0;
    end else if (take && stateQ == ST_BODY) begin
      matchQ <= matchNext;
    end
  end

  // ---------------------------------------------------------------
  // Copy index, saturating so an endless supply never wraps
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || start) begin
      copyQ <= '0;
    end else if (stateQ == ST_JUDGE && !crcGood && copyQ != COPY_MAX) begin
      copyQ <= copyQ + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Verdict record and strobe
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || start) begin
      result       <= '0;
      resultStrobe <= 1'b0;
    end else if (stateQ == ST_JUDGE) begin
      result.pass   <= crcGood;
      result.fail   <= !crcGood;
      result.absent <= 1'b0;
      result.copy   <= copyQ;
      result.crc    <= crcQ;
      resultStrobe  <= 1'b1;
    end else if (absentNow) begin
      result.pass   <= 1'b0;
      result.fail   <= 1'b0; // No CRC was judged on a missing copy
      result.absent <= 1'b1;
      result.copy   <= copyQ;
      result.crc    <= crcQ;
      resultStrobe  <= 1'b1;
    end else begin
      resultStrobe <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Activity flags
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      done <= 1'b0;
    end else if ((stateQ == ST_JUDGE && crcGood) || absentNow) begin
      busy <= 1'b0;
      done <= 1'b1;
    end
  end

endmodule

// ---------------------------------------------------------------
// Byte FIFO: valid/ready on both sides, flush empties it in one cycle
// ---------------------------------------------------------------
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtrQ;
  logic [AW-1:0]    rdPtrQ;
  logic [AW:0]      cntQ;
  logic             push;
  logic             pop;

  // Handshakes on both sides
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outValid = (cntQ != '0);
  assign outData  = mem[rdPtrQ];

  // Storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtrQ] <= inData;
    end
  end

  // Pointers, fill count and registered ready; ready drops with the last free slot
  always_ff @(posedge mclk) begin
    if (srst || flush) begin
      wrPtrQ  <= '0;
      rdPtrQ  <= '0;
      cntQ    <= '0;
      inReady <= 1'b1;
    end else begin
      if (push) wrPtrQ <= wrPtrQ + 1'b1;
      if (pop)  rdPtrQ <= rdPtrQ + 1'b1;
      cntQ    <= cntQ + (AW+1)'(push) - (AW+1)'(pop);
      inReady <= (cntQ + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
    end
  end

endmodule

// [verilog/ppcrc_pkg.sv]
// Constants, types and states shared by the parameter page CRC checker.
// Assumes a single clock domain; no other files are needed.
package ppcrc_pkg;

  // ---------------------------------------------------------------
  // Widths and layout of one copy
  // ---------------------------------------------------------------
  localparam int        BYTE_W      = 8;
  localparam int        CRC_W       = 16;
  localparam int        POS_W       = 9;
  localparam int        COPY_W      = 8;
  localparam int        FIFO_DEPTH  = 16;
  localparam logic [8:0] COVER_LAST = 9'h1FD;  // Byte 509
  localparam logic [8:0] STORED_LO  = 9'h1FE;  // Byte 510
  localparam logic [8:0] STORED_HI  = 9'h1FF;  // Byte 511
  localparam logic [8:0] PROBE_LAST = 9'h003;  // Last byte of the first word
  localparam logic [2:0] SIG_MIN    = 3'h2;    // Matching bytes needed
  localparam logic [7:0] COPY_FIXED = 8'h03;   // Primary plus two mandatory copies
  localparam logic [7:0] COPY_MAX   = 8'hFF;

  // ---------------------------------------------------------------
  // CRC definition
  // ---------------------------------------------------------------
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'h4F4E;

  // ---------------------------------------------------------------
  // Checker states and verdict record
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_BODY   = 3'b001,
    ST_STORED = 3'b010,
    ST_JUDGE  = 3'b011,
    ST_DONE   = 3'b100
  } state_t;

  typedef struct packed {
    logic              pass;    // Computed CRC equals stored word
    logic              fail;    // Mismatch on this copy
    logic              absent;  // Further copy failed the signature probe
    logic [7:0]        copy;    // Copy index, 0 = primary
    logic [15:0]       crc;     // Computed CRC of this copy
  } result_t;

endpackage
